/* File: verilog/bcg_defines.svh */
`ifndef BCG_DEFINES_SVH
`define BCG_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define BCG_OFF_MODE      12'h000
`define BCG_OFF_TCTRL     12'h004
`define BCG_OFF_PRESET    12'h008
`define BCG_OFF_STATUS    12'h00c
`define BCG_OFF_PORT      12'h010

// ****************************************
// Field positions
// ****************************************
`define BCG_MODE_SEL0_BIT 0
`define BCG_MODE_SEL1_BIT 1
`define BCG_MODE_SEL2_BIT 2
`define BCG_ARB_LO_BIT    3
`define BCG_ARB_HI_BIT    4
`define BCG_TCTRL_EN_BIT  0
`define BCG_TCTRL_TRG_BIT 1
`define BCG_PORT_OE_BIT   0
`define BCG_PORT_OUT_BIT  1

// ****************************************
// Reset values
// ****************************************
`define BCG_MODE_RST      5'h17
`define BCG_TCTRL_RST     2'h0
`define BCG_PRESET_RST    24'h0003e8
`define BCG_PORT_RST      2'h0

`endif

/* File: verilog/bcg_pkg.sv */
package bcg_pkg;

    typedef enum logic [1:0] {
        BCG_ARB_PRI = 2'h0,
        BCG_ARB_RRS = 2'h1,
        BCG_ARB_PRR = 2'h2
    } bcg_arb_type;

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } bcg_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } bcg_apb_rsp_type;

    typedef struct packed {
        logic       higher_req;
        logic       any_req;
        logic       level3_req;
        logic       grant;
    } bcg_arb_in_type;

endpackage

/* File: verilog/bcg_timer.sv */
`include "bcg_defines.svh"

module bcg_timer #(
    parameter int WIDTH = 24
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             enable,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] preset,
    output logic                  expired,
    output logic [WIDTH-1:0]      count
);
    import bcg_pkg::*;

    logic [WIDTH-1:0] count_q;
    logic             exp_q;

    // Retriggerable one-shot: every restart while enabled reloads the full timeout.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= '0;
            exp_q   <= 1'b0;
        end else if (!enable) begin
            count_q <= '0;
            exp_q   <= 1'b0;
        end else if (restart) begin
            count_q <= preset;     // RULE10
            exp_q   <= 1'b0;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
            exp_q   <= (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    assign expired = exp_q;
    assign count   = count_q;

    a_restart_reload: assert property (@(posedge mclk) disable iff (sys_rst)
        enable && restart |=> count_q == $past(preset) && !exp_q) // RULE10
        else $error("timer did not reload on restart");

endmodule

/* File: verilog/bcg_top.sv */
// Operation
// RULE1: Clear output combines arbiter and timer requests.
// RULE2: Clear depends on arbitration, mode, timer setup.
// RULE3: Three select bits choose clear mode.
// RULE4: After reset timer pins are high inputs.
// RULE5: Reset default clears on pending level-3 request.
// RULE6: Timer control selects timer or port pins.
// RULE7: Timer mode drives timer clear on output pin.
// RULE8: Trigger pin enables watchdog count.
// RULE9: Timer guarantees each master minimum tenure.
// RULE10: Retriggerable one-shot with programmable timeout.
// RULE11: Every bus grant restarts the watchdog.
// RULE12: Software never makes trigger pin an output.
// RULE13: Select codes map to combine functions.
// RULE14: Arbiter condition depends on arbitration type.
// RULE15: Forbidden codes never assert clear.
`include "bcg_defines.svh"

module bcg_top #(
    parameter int TWIDTH = 24
) (
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire bcg_pkg::bcg_apb_req_type apb_req,
    output bcg_pkg::bcg_apb_rsp_type      apb_rsp,
    input  wire bcg_pkg::bcg_arb_in_type  arb_in,
    input  wire logic                     timer_trigger_pin_i,
    output logic                          timer_trigger_pin_o,
    output logic                          timer_trigger_pin_oe,
    input  wire logic                     timer_output_pin_i,
    output logic                          timer_output_pin_o,
    output logic                          timer_output_pin_oe,
    output logic                          bus_clear_n
);
    import bcg_pkg::*;

    // ****************************************
    // Synchronisers
    // ****************************************
    logic [4:0] s1_q;
    logic [4:0] s2_q;

    // Requests reset to their idle low level and pins to their pulled-up high level.
    // A request bit reset high would raise a false clear just after reset.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 5'h03;
            s2_q <= 5'h03;
        end else begin
            s1_q <= {arb_in.higher_req, arb_in.any_req, arb_in.level3_req,
                     timer_trigger_pin_i, timer_output_pin_i};
            s2_q <= s1_q;
        end
    end

    logic higher_req_s;
    logic any_req_s;
    logic level3_req_s;
    logic trig_pin_s;
    logic out_pin_s;
    assign {higher_req_s, any_req_s, level3_req_s, trig_pin_s, out_pin_s} = s2_q;

    // Grant comes from on-board arbiter logic on this clock.
    logic grant_q;
    logic grant_rise;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            grant_q <= 1'b0;
        end else begin
            grant_q <= arb_in.grant;
        end
    end
    assign grant_rise = arb_in.grant && !grant_q;

    // ****************************************
    // Registers
    // ****************************************
    logic [4:0]        mode_q;
    logic [1:0]        tctrl_q;
    logic [TWIDTH-1:0] preset_q;
    logic [1:0]        port_q;

    logic wr_en;
    logic [11:0] off;
    assign off   = apb_req.paddr[11:0];
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;

    function automatic logic known_off(input logic [11:0] a);
        known_off = (a == `BCG_OFF_MODE) || (a == `BCG_OFF_TCTRL) ||
                    (a == `BCG_OFF_PRESET) || (a == `BCG_OFF_STATUS) ||
                    (a == `BCG_OFF_PORT);
    endfunction

    // Reset default is mode 1,1,1 with prioritized round robin.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= `BCG_MODE_RST; // RULE5
        end else if (wr_en && off == `BCG_OFF_MODE) begin
            mode_q <= apb_req.pwdata[4:0]; // RULE3
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tctrl_q  <= `BCG_TCTRL_RST;
            preset_q <= TWIDTH'(`BCG_PRESET_RST);
        end else if (wr_en && off == `BCG_OFF_TCTRL) begin
            tctrl_q <= apb_req.pwdata[1:0]; // RULE6
        end else if (wr_en && off == `BCG_OFF_PRESET) begin
            preset_q <= apb_req.pwdata[TWIDTH-1:0];
        end
    end

    // The trigger pin output enable is never set from software: driving it
    // could fight external circuitry on the board.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port_q <= `BCG_PORT_RST;
        end else if (wr_en && off == `BCG_OFF_PORT) begin
            port_q <= apb_req.pwdata[1:0];
        end
    end

    logic timer_en;
    logic [TWIDTH-1:0] tcount;
    logic timer_clear_request;
    assign timer_en = tctrl_q[`BCG_TCTRL_EN_BIT];

    // ****************************************
    // Bus-clear combination
    // ****************************************
    logic arbiter_clear_request;
    logic clear_d;
    logic clear_q;

    function automatic logic arb_cond(input logic [1:0] at, input logic hi,
                                      input logic any, input logic l3);
        case (at)
            BCG_ARB_PRI: arb_cond = hi;
            BCG_ARB_RRS: arb_cond = any;
            BCG_ARB_PRR: arb_cond = l3;
            default:     arb_cond = l3;
        endcase
    endfunction

    function automatic logic combine(input logic [2:0] sel, input logic a,
                                     input logic t);
        case (sel)
            3'h7:    combine = a;
            3'h1:    combine = t;
            3'h5:    combine = a | t;
            3'h2:    combine = a & t;
            default: combine = 1'b0;
        endcase
    endfunction

    assign arbiter_clear_request = arb_cond(mode_q[4:3], higher_req_s, any_req_s,
                                            level3_req_s); // RULE14

    // Select bits packed as sel0 sel1 sel2 from msb to lsb.
    logic [2:0] sel;
    assign sel = {mode_q[`BCG_MODE_SEL0_BIT], mode_q[`BCG_MODE_SEL1_BIT],
                  mode_q[`BCG_MODE_SEL2_BIT]};

    // Forbidden codes fall to the default and never assert.
    assign clear_d = combine(sel, arbiter_clear_request,
                             timer_clear_request); // RULE1 RULE2 RULE13 RULE15

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clear_q <= 1'b0;
        end else begin
            clear_q <= clear_d;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    logic trig_ok;
    logic restart;
    // The trigger pin gates counting only when software asks for it.
    // While the trigger is low the counter keeps reloading, so counting
    // always starts from the full timeout once the trigger rises.
    assign trig_ok = !tctrl_q[`BCG_TCTRL_TRG_BIT] || trig_pin_s; // RULE8
    assign restart = grant_rise || !trig_ok; // RULE8 RULE11

    // Each grant reloads the timeout, so a master keeps the bus at least
    // the preset time before the timer can request a clear.
    bcg_timer #(
        .WIDTH (TWIDTH)
    ) u_timer (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .enable  (timer_en), // RULE9
        .restart (restart),
        .preset  (preset_q),
        .expired (),
        .count   (tcount)
    );

    logic tmr_clr_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr_clr_q <= 1'b0;
        end else begin
            tmr_clr_q <= timer_en && trig_ok && !restart && (tcount == '0) &&
                         grant_q;
        end
    end
    assign timer_clear_request = tmr_clr_q;

    // ****************************************
    // Pins and outputs
    // ****************************************
    logic timer_output_o_q;
    logic timer_output_oe_q;
    logic bclr_n_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_output_o_q  <= 1'b1; // RULE4
            timer_output_oe_q <= 1'b0; // RULE4
        end else if (timer_en) begin
            timer_output_o_q  <= !timer_clear_request; // RULE7
            timer_output_oe_q <= 1'b1; // RULE7
        end else begin
            timer_output_o_q  <= port_q[`BCG_PORT_OUT_BIT]; // RULE6
            timer_output_oe_q <= port_q[`BCG_PORT_OE_BIT];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bclr_n_q <= 1'b1;
        end else begin
            bclr_n_q <= !clear_q;
        end
    end

    assign timer_output_pin_o   = timer_output_o_q;
    assign timer_output_pin_oe  = timer_output_oe_q;
    assign timer_trigger_pin_o  = 1'b1;
    assign timer_trigger_pin_oe = 1'b0; // RULE12
    assign bus_clear_n          = bclr_n_q;

    // ****************************************
    // APB read path
    // ****************************************
    logic [31:0] rdata_q;
    logic        ready_q;
    logic        err_q;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (off)
            `BCG_OFF_MODE:   rd_mux = {27'h0, mode_q};
            `BCG_OFF_TCTRL:  rd_mux = {30'h0, tctrl_q};
            `BCG_OFF_PRESET: rd_mux = 32'(preset_q);
            `BCG_OFF_STATUS: rd_mux = {26'h0, trig_pin_s, out_pin_s, clear_q,
                                       timer_clear_request, arbiter_clear_request,
                                       tcount == '0};
            `BCG_OFF_PORT:   rd_mux = {30'h0, port_q};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero-wait: pready rises in the first access cycle.
    // Read data is captured from the setup cycle so that it stands beside pready.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= (apb_req.psel && !apb_req.penable && !apb_req.pwrite) ?
                       rd_mux : rdata_q;
            ready_q <= apb_req.psel && !apb_req.penable;
            err_q   <= apb_req.psel && !apb_req.penable && !known_off(off);
        end
    end

    assign apb_rsp.prdata  = rdata_q;
    assign apb_rsp.pready  = ready_q;
    assign apb_rsp.pslverr = err_q;

    // ****************************************
    // Checks
    // ****************************************
    a_forbidden_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        !(sel inside {3'h7, 3'h1, 3'h5, 3'h2}) |=> !clear_q) // RULE15
        else $error("forbidden code asserted clear");

    a_arb_only_mode: assert property (@(posedge mclk) disable iff (sys_rst)
        sel == 3'h7 |=> clear_q == $past(arbiter_clear_request)) // RULE13
        else $error("arbiter-only mode wrong");

    a_and_mode: assert property (@(posedge mclk) disable iff (sys_rst)
        sel == 3'h2 && !timer_clear_request |=> !clear_q) // RULE1
        else $error("and mode asserted without timer");

    a_prr_cond: assert property (@(posedge mclk) disable iff (sys_rst)
        mode_q[4:3] == BCG_ARB_PRR |-> arbiter_clear_request == level3_req_s) // RULE14
        else $error("prr condition wrong");

    a_bclr_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        clear_d |=> ##1 !bus_clear_n) // RULE2
        else $error("bus clear output late");

    a_timer_output_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        timer_en |=> timer_output_pin_oe) // RULE7
        else $error("timer output pin not driven");

    a_trig_no_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        !timer_trigger_pin_oe) // RULE12
        else $error("trigger pin driven");

    a_grant_tenure: assert property (@(posedge mclk) disable iff (sys_rst)
        restart && preset_q > 2 |=> !timer_clear_request [*2]) // RULE9 RULE11
        else $error("clear raised before tenure");

endmodule

/* File: verif/bcg_arb_model.sv */
// ****************************************
// Arbiter and bus master stand-in
// ****************************************
module bcg_arb_model
    import bcg_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic [2:0]          want_req,
    input  wire logic                want_grant,
    input  wire logic                slow,
    output bcg_pkg::bcg_arb_in_type  arb_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] gdly_q;

    // A slow arbiter hands out the grant three cycles late, as a busy bus would.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            arb_in <= '0;
            gdly_q <= '0;
        end else begin
            arb_in.higher_req <= want_req[0];
            arb_in.any_req    <= want_req[1];
            arb_in.level3_req <= want_req[2];
            gdly_q            <= {gdly_q[1:0], want_grant};
            arb_in.grant      <= slow ? gdly_q[2] : want_grant;
        end
    end
endmodule

/* File: verif/bus_clear_generation_test.sv */
`include "bcg_defines.svh"

module bus_clear_generation_test;
    import bcg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int P = 12;

    logic            mclk            = 1'b0;
    logic            sys_rst         = 1'b1;
    bcg_apb_req_type req             = '0;
    bcg_apb_rsp_type rsp;
    bcg_arb_in_type  arb_in;
    logic [2:0]      want_req        = 3'h0;
    logic [2:0]      r;
    logic            want_grant      = 1'b0;
    logic            slow            = 1'b0;
    logic            trig_ext        = 1'b1;
    logic            trig_o;
    logic            trig_oe;
    logic            out_o;
    logic            out_oe;
    logic            bus_clear_n;
    logic [31:0]     rd;
    logic            err;
    int              err_count       = 0;
    int              samples_checked = 0;
    int              seed            = 32'h8dd4;
    int              n;

    // Both pins are pulled up on the board, so an undriven pin reads high.
    wire trig_w = trig_oe ? trig_o : trig_ext;
    wire out_w  = out_oe ? out_o : 1'b1;

    always #5 mclk = ~mclk;

    bcg_top #(.TWIDTH(24)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .arb_in(arb_in),
        .timer_trigger_pin_i(trig_w), .timer_trigger_pin_o(trig_o),
        .timer_trigger_pin_oe(trig_oe), .timer_output_pin_i(out_w),
        .timer_output_pin_o(out_o), .timer_output_pin_oe(out_oe), .bus_clear_n(bus_clear_n));

    bcg_arb_model u_arb (
        .mclk(mclk), .sys_rst(sys_rst), .want_req(want_req), .want_grant(want_grant),
        .slow(slow), .arb_in(arb_in));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k = 0;
        @(posedge mclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= {20'h0, a};
        req.pwdata  <= wd;
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        chk("pready", 1, (k < 20));
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wait_clear(input int lim);
        n = 0;
        while (bus_clear_n !== 1'b0 && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // Expected clear level from arbitration type, select code, requests and timer.
    function automatic logic clr_model(int code, int arb, logic [2:0] q, logic t);
        logic a;
        a = (arb == 0) ? q[0] : (arb == 1) ? q[1] : q[2];
        case (code)
            7: return a;
            4: return t;
            5: return a | t;
            2: return a & t;
            default: return 1'b0;
        endcase
    endfunction

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk("bus_clear_n", 1, bus_clear_n);
        chk("trig_oe", 0, trig_oe);
        chk("out_oe", 0, out_oe);
        apb(0, `BCG_OFF_MODE, 0);
        chk("mode", 32'h17, rd);
        apb(0, `BCG_OFF_STATUS, 0);
        chk("pin levels", 3, rd[5:4]);
        want_req <= 3'b100;
        repeat (8) @(posedge mclk);
        chk("default clear", 0, bus_clear_n);
        want_req <= 3'b011;
        repeat (8) @(posedge mclk);
        chk("default no clear", 1, bus_clear_n);
        $display("test reset defaults done");

        for (int t = 0; t < 2; t++) begin
            apb(1, `BCG_OFF_PRESET, 32'h3);
            apb(1, `BCG_OFF_TCTRL, 32'(t));
            slow <= 1'b1;
            want_grant <= t[0];
            repeat (20) @(posedge mclk);
            for (int arb = 0; arb < 3; arb++) begin
                for (int code = 0; code < 8; code++) begin
                    r = 3'($random(seed));
                    apb(1, `BCG_OFF_MODE, 32'(arb * 8 + code));
                    want_req <= r;
                    repeat (8) @(posedge mclk);
                    chk("bus_clear_n", !clr_model(code, arb, r, t[0]), bus_clear_n);
                    chk("out_oe", t, out_oe);
                    chk("out_w", !t[0], out_w);
                    chk("trig_oe", 0, trig_oe);
                end
            end
            apb(0, `BCG_OFF_MODE, 0);
            chk("mode readback", 32'h17, rd);
        end
        $display("test mode table done");

        slow <= 1'b0;
        want_req <= 3'h0;
        want_grant <= 1'b0;
        apb(1, `BCG_OFF_MODE, 32'h14);
        apb(1, `BCG_OFF_PRESET, 32'(P));
        repeat (8) @(posedge mclk);
        chk("idle no clear", 1, bus_clear_n);
        want_grant <= 1'b1;
        wait_clear(P + 12);
        chk("tenure lower", 1, (n >= P));
        chk("tenure upper", 1, (n < P + 12));
        want_grant <= 1'b0;
        repeat (4) @(posedge mclk);
        want_grant <= 1'b1;
        repeat (P - 4) @(posedge mclk);
        want_grant <= 1'b0;
        @(posedge mclk);
        want_grant <= 1'b1;
        wait_clear(P + 12);
        chk("retrigger wait", 1, (n >= P - 2));
        chk("retrigger clear", 1, (n < P + 12));
        $display("test timer tenure done");

        apb(1, `BCG_OFF_TCTRL, 32'h3);
        trig_ext <= 1'b0;
        want_grant <= 1'b0;
        @(posedge mclk);
        want_grant <= 1'b1;
        repeat (3 * P) @(posedge mclk);
        chk("trigger held low", 1, bus_clear_n);
        trig_ext <= 1'b1;
        wait_clear(P + 12);
        chk("trigger high", 1, (n < P + 12));
        chk("trigger tenure", 1, (n >= P));
        $display("test trigger done");

        // Software only ever programs the output pin; the trigger pin stays an input.
        apb(1, `BCG_OFF_TCTRL, 32'h0);
        apb(1, `BCG_OFF_PORT, 32'h1);
        repeat (2) @(posedge mclk);
        chk("port oe", 1, out_oe);
        chk("port level", 0, out_o);
        apb(0, `BCG_OFF_STATUS, 0);
        chk("status out pin", 0, rd[4]);
        chk("trig_oe", 0, trig_oe);
        $display("test port mode done");

        apb(1, 12'h020, 32'h0);
        chk("unmapped write err", 1, err);
        apb(0, 12'h020, 0);
        chk("unmapped read err", 1, err);
        chk("unmapped read data", 0, rd);
        apb(0, `BCG_OFF_MODE, 0);
        chk("mode kept", 32'h14, rd);
        $display("test unmapped done");

        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("clear in reset", 1, bus_clear_n);
        chk("out_oe in reset", 0, out_oe);
        sys_rst <= 1'b0;
        apb(0, `BCG_OFF_MODE, 0);
        chk("mode after reset", 32'h17, rd);
        $display("test second reset done");
        complete_run;
    end

    initial begin
        #500000;
        err_count++;
        $display("[ERR] run expected done seen timeout");
        complete_run;
    end
endmodule
